// *** src/secure_link_port_counters.sv ***
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps

module secure_link_port_counters #(
    parameter int OCT_W = port_stats_pkg::OCT_W
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // Transmit events
    input  wire logic                tx_pkt_valid,
    input  wire logic                tx_packet_secure_flag,
    input  wire logic                tx_encrypt_flag,
    input  wire logic [OCT_W-1:0]    tx_user_octets,
    // Receive events
    input  wire logic                rx_pkt_valid,
    input  wire logic                rx_untagged,
    input  wire logic                rx_encrypted,
    input  wire logic                rx_protected,
    input  wire logic [OCT_W-1:0]    rx_user_octets,
    input  wire logic                rx_bad_tag,
    input  wire logic                rx_unknown_id,
    input  wire logic                rx_forwarded,
    // Enable fields for the datapath
    output logic [1:0]               tx_secure_enable_field,
    output logic [1:0]               rx_secure_enable_field,
    // AXI4-Lite slave
    input  wire logic [15:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [15:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [15:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        wr_fire;
    logic        ctrl_hit;
    logic        tx_gate;
    logic        rx_gate;

    assign wr_fire  = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign ctrl_hit = awaddr_q == port_stats_pkg::SECURE_CONTROL_ADDR;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_secure_enable_field <= port_stats_pkg::CTRL_RESET[1:0];
            rx_secure_enable_field <= port_stats_pkg::CTRL_RESET[3:2];
        end
        else if (wr_fire && ctrl_hit && wstrb_q[0])
        begin
            tx_secure_enable_field <= wdata_q[port_stats_pkg::TX_EN_LSB +: 2];
            rx_secure_enable_field <= wdata_q[port_stats_pkg::RX_EN_LSB +: 2];
        end
    end

    // Either documented enable mode turns the untagged counters on
    assign tx_gate = tx_secure_enable_field == port_stats_pkg::EN_MODE_A ||
                     tx_secure_enable_field == port_stats_pkg::EN_MODE_B;
    assign rx_gate = rx_secure_enable_field == port_stats_pkg::EN_MODE_A ||
                     rx_secure_enable_field == port_stats_pkg::EN_MODE_B;

    // ----------------------------------------------------------------
    // Increment amounts per counter
    // ----------------------------------------------------------------
    logic [31:0] inc [port_stats_pkg::NUM_CNT];
    logic        tx_ctl;
    logic [31:0] tx_oct;
    logic [31:0] rx_oct;

    assign tx_ctl = tx_pkt_valid && tx_packet_secure_flag;
    assign tx_oct = 32'(tx_user_octets);
    assign rx_oct = 32'(rx_user_octets);

    always_comb
    begin
        inc[port_stats_pkg::C_TX_UT]   = 32'(tx_pkt_valid && !tx_packet_secure_flag && tx_gate);
        inc[port_stats_pkg::C_TX_EP]   = 32'(tx_ctl && tx_encrypt_flag);
        inc[port_stats_pkg::C_TX_PP]   = 32'(tx_ctl && !tx_encrypt_flag);
        inc[port_stats_pkg::C_TX_EO]   = (tx_ctl && tx_encrypt_flag) ? tx_oct : 32'h0000_0000;
        inc[port_stats_pkg::C_TX_PO]   = (tx_ctl && !tx_encrypt_flag) ? tx_oct : 32'h0000_0000;
        inc[port_stats_pkg::C_RX_UT]   = 32'(rx_pkt_valid && rx_untagged && rx_gate);
        // Integrity outcome is not an input: octets count regardless
        inc[port_stats_pkg::C_RX_DO]   = (rx_pkt_valid && rx_protected && rx_encrypted)
                                         ? rx_oct : 32'h0000_0000;
        inc[port_stats_pkg::C_RX_VO]   = (rx_pkt_valid && rx_protected && !rx_encrypted)
                                         ? rx_oct : 32'h0000_0000;
        inc[port_stats_pkg::C_RX_BAD]  = 32'(rx_pkt_valid && rx_bad_tag);
        inc[port_stats_pkg::C_RX_NOID] = 32'(rx_pkt_valid && rx_unknown_id && !rx_forwarded);
        inc[port_stats_pkg::C_RX_UNK]  = 32'(rx_pkt_valid && rx_unknown_id && rx_forwarded);
    end

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    logic                               rd_fire;
    logic [port_stats_pkg::NUM_CNT-1:0] rd_sel;
    logic                               rd_ctrl;
    logic [15:0]                        cnt_addr [port_stats_pkg::NUM_CNT];

    assign cnt_addr[port_stats_pkg::C_TX_UT]   = port_stats_pkg::TX_UNTAGGED_PKT_ADDR;
    assign cnt_addr[port_stats_pkg::C_TX_EP]   = port_stats_pkg::TX_ENC_PKT_ADDR;
    assign cnt_addr[port_stats_pkg::C_TX_PP]   = port_stats_pkg::TX_PROT_PKT_ADDR;
    assign cnt_addr[port_stats_pkg::C_TX_EO]   = port_stats_pkg::TX_ENC_OCT_ADDR;
    assign cnt_addr[port_stats_pkg::C_TX_PO]   = port_stats_pkg::TX_PROT_OCT_ADDR;
    assign cnt_addr[port_stats_pkg::C_RX_UT]   = port_stats_pkg::RX_UNTAGGED_PKT_ADDR;
    assign cnt_addr[port_stats_pkg::C_RX_DO]   = port_stats_pkg::RX_DEC_OCT_ADDR;
    assign cnt_addr[port_stats_pkg::C_RX_VO]   = port_stats_pkg::RX_VAL_OCT_ADDR;
    assign cnt_addr[port_stats_pkg::C_RX_BAD]  = port_stats_pkg::RX_BAD_TAG_ADDR;
    assign cnt_addr[port_stats_pkg::C_RX_NOID] = port_stats_pkg::RX_NO_ID_DROP_ADDR;
    assign cnt_addr[port_stats_pkg::C_RX_UNK]  = port_stats_pkg::RX_UNK_ID_FWD_ADDR;

    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_ctrl = s_axi_araddr == port_stats_pkg::SECURE_CONTROL_ADDR;

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    logic [31:0] cnt_q [port_stats_pkg::NUM_CNT];

    genvar gi;
    generate
        for (gi = 0; gi < port_stats_pkg::NUM_CNT; gi++)
        begin : g_cnt
            assign rd_sel[gi] = rd_fire && s_axi_araddr == cnt_addr[gi];

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    cnt_q[gi] <= port_stats_pkg::CNT_RESET;
                else if (rd_sel[gi])
                    cnt_q[gi] <= inc[gi];
                else
                    cnt_q[gi] <= cnt_q[gi] + inc[gi];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i < port_stats_pkg::NUM_CNT; i++)
        begin
            if (s_axi_araddr == cnt_addr[i])
                rd_mux = cnt_q[i];
        end
        if (rd_ctrl)
            rd_mux = {28'h000_0000, rx_secure_enable_field, tx_secure_enable_field};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= port_stats_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= (|rd_sel || rd_ctrl) ? port_stats_pkg::RESP_OKAY
                                                     : port_stats_pkg::RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    // Counters are read-clear only; writes to them are dropped and answered with SLVERR
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= 16'h0000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= port_stats_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= ctrl_hit ? port_stats_pkg::RESP_OKAY
                                         : port_stats_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_read_clears: assert property (rd_sel[port_stats_pkg::C_RX_BAD] |=>
        cnt_q[port_stats_pkg::C_RX_BAD] == $past(inc[port_stats_pkg::C_RX_BAD]))
        else $error("read did not clear counter");
    chk_read_value: assert property (rd_sel[port_stats_pkg::C_TX_EP] |=>
        s_axi_rdata == $past(cnt_q[port_stats_pkg::C_TX_EP]))
        else $error("read data differs from counter");
    chk_tx_untag_gate: assert property (!tx_gate && !rd_sel[port_stats_pkg::C_TX_UT] |=>
        $stable(cnt_q[port_stats_pkg::C_TX_UT]))
        else $error("tx untagged moved while disabled");
    chk_tx_enc_pkt: assert property (tx_ctl && tx_encrypt_flag
        && !rd_sel[port_stats_pkg::C_TX_EP] |=>
        cnt_q[port_stats_pkg::C_TX_EP] == $past(cnt_q[port_stats_pkg::C_TX_EP]) + 32'h1)
        else $error("encrypted packet not counted");
    chk_tx_prot_oct: assert property (tx_ctl && !tx_encrypt_flag
        && !rd_sel[port_stats_pkg::C_TX_PO] |=>
        cnt_q[port_stats_pkg::C_TX_PO] == $past(cnt_q[port_stats_pkg::C_TX_PO]) + $past(tx_oct))
        else $error("protected octets not added");
    chk_rx_untag_gate: assert property (!rx_gate && !rd_sel[port_stats_pkg::C_RX_UT] |=>
        $stable(cnt_q[port_stats_pkg::C_RX_UT]))
        else $error("rx untagged moved while disabled");
    chk_rx_dec_oct: assert property (rx_pkt_valid && rx_protected && rx_encrypted
        && !rd_sel[port_stats_pkg::C_RX_DO] |=>
        cnt_q[port_stats_pkg::C_RX_DO] == $past(cnt_q[port_stats_pkg::C_RX_DO]) + $past(rx_oct))
        else $error("decrypted octets not added");
    chk_rx_val_oct: assert property (rx_pkt_valid && rx_protected && !rx_encrypted
        && !rd_sel[port_stats_pkg::C_RX_VO] |=>
        cnt_q[port_stats_pkg::C_RX_VO] == $past(cnt_q[port_stats_pkg::C_RX_VO]) + $past(rx_oct))
        else $error("validated octets not added");
    chk_no_id_drop: assert property (rx_pkt_valid && rx_unknown_id && !rx_forwarded
        && !rd_sel[port_stats_pkg::C_RX_NOID] |=>
        cnt_q[port_stats_pkg::C_RX_NOID] == $past(cnt_q[port_stats_pkg::C_RX_NOID]) + 32'h1)
        else $error("dropped unknown id not counted");
    chk_read_answer: assert property (rd_fire |=> s_axi_rvalid)
        else $error("read answer late");

    cov_read_clear_hit: cover property (rd_sel[port_stats_pkg::C_RX_BAD] && rx_pkt_valid && rx_bad_tag);
    cov_ctrl_write:     cover property (wr_fire && ctrl_hit);
    cov_tx_untagged:    cover property (inc[port_stats_pkg::C_TX_UT] != 32'h0000_0000);

endmodule // secure_link_port_counters

// *** src/port_stats_pkg.sv ***
package port_stats_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int          ADDR_W                = 16;
    localparam int          DATA_W                = 32;
    localparam int          NUM_CNT               = 11;
    localparam int          OCT_W                 = 16;
    localparam logic [15:0] TX_UNTAGGED_PKT_ADDR  = 16'h4300;
    localparam logic [15:0] TX_ENC_PKT_ADDR       = 16'h4304;
    localparam logic [15:0] TX_PROT_PKT_ADDR      = 16'h4308;
    localparam logic [15:0] TX_ENC_OCT_ADDR       = 16'h430C;
    localparam logic [15:0] TX_PROT_OCT_ADDR      = 16'h4310;
    localparam logic [15:0] RX_UNTAGGED_PKT_ADDR  = 16'h4314;
    localparam logic [15:0] RX_DEC_OCT_ADDR       = 16'h431C;
    localparam logic [15:0] RX_VAL_OCT_ADDR       = 16'h4320;
    localparam logic [15:0] RX_BAD_TAG_ADDR       = 16'h4324;
    localparam logic [15:0] RX_NO_ID_DROP_ADDR    = 16'h4328;
    localparam logic [15:0] RX_UNK_ID_FWD_ADDR    = 16'h432C;
    localparam logic [15:0] SECURE_CONTROL_ADDR   = 16'h4330;

    // ----------------------------------------------------------------
    // Fields and values
    // ----------------------------------------------------------------
    localparam int          TX_EN_LSB             = 0;
    localparam int          RX_EN_LSB             = 2;
    localparam logic [1:0]  EN_MODE_A             = 2'h1;
    localparam logic [1:0]  EN_MODE_B             = 2'h2;
    localparam logic [31:0] CNT_RESET             = 32'h0000_0000;
    localparam logic [3:0]  CTRL_RESET            = 4'h0;
    localparam logic [1:0]  RESP_OKAY             = 2'h0;
    localparam logic [1:0]  RESP_SLVERR           = 2'h2;

    // Counter indices
    localparam int          C_TX_UT   = 0;
    localparam int          C_TX_EP   = 1;
    localparam int          C_TX_PP   = 2;
    localparam int          C_TX_EO   = 3;
    localparam int          C_TX_PO   = 4;
    localparam int          C_RX_UT   = 5;
    localparam int          C_RX_DO   = 6;
    localparam int          C_RX_VO   = 7;
    localparam int          C_RX_BAD  = 8;
    localparam int          C_RX_NOID = 9;
    localparam int          C_RX_UNK  = 10;

endpackage

// *** dv/secure_link_port_counters_bench.sv ***
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end

module secure_link_port_counters_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        tx_pkt_valid = 1'b0, tx_sec = 1'b0, tx_enc = 1'b0;
    logic [15:0] tx_oct = 16'h0000, rx_oct = 16'h0000;
    logic        rx_pkt_valid = 1'b0, rx_untag = 1'b0, rx_enc = 1'b0, rx_prot = 1'b0;
    logic        rx_bad = 1'b0, rx_unk = 1'b0, rx_fwd = 1'b0;
    logic [1:0]  tx_en, rx_en, bresp, rresp;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    int          n_errors = 0;
    int          checks = 0;
    localparam logic [15:0] CTRL = port_stats_pkg::SECURE_CONTROL_ADDR;
    localparam logic [1:0]  OK = port_stats_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR = port_stats_pkg::RESP_SLVERR;
    localparam logic [15:0] CNT_ADDR [11] = '{16'h4300, 16'h4304, 16'h4308, 16'h430C,
        16'h4310, 16'h4314, 16'h431C, 16'h4320, 16'h4324, 16'h4328, 16'h432C};

    always #2 aclk = ~aclk;

    secure_link_port_counters dut_u (
        .aclk(aclk), .aresetn(aresetn), .tx_pkt_valid(tx_pkt_valid),
        .tx_packet_secure_flag(tx_sec), .tx_encrypt_flag(tx_enc), .tx_user_octets(tx_oct),
        .rx_pkt_valid(rx_pkt_valid), .rx_untagged(rx_untag), .rx_encrypted(rx_enc),
        .rx_protected(rx_prot), .rx_user_octets(rx_oct), .rx_bad_tag(rx_bad),
        .rx_unknown_id(rx_unk), .rx_forwarded(rx_fwd), .tx_secure_enable_field(tx_en),
        .rx_secure_enable_field(rx_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    // ------------------------------------------------------------
    // Bus and event tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic tmo(int n);
        if (n >= 100)
        begin
            n_errors++;
            $display("unexpected bus_wait expected answer seen none");
            print_verdict();
        end
    endtask

    // Poke raises an rx event at the address handshake edge
    task automatic rd(input logic [15:0] a, input bit poke, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (poke)
                rx_pkt_valid <= (n == 1);
        end while (!arready && n < 100);
        arvalid <= 1'b0;
        while (!rvalid && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        tmo(n);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] r);
        int  n;
        bit  aw, w;
        n = 0;
        aw = 0;
        w = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready && !aw)
                awvalid <= 1'b0;
            if (wready && !w)
                wvalid <= 1'b0;
            aw = aw | awready;
            w = w | wready;
        end while (!(aw && w) && n < 100);
        while (!bvalid && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        tmo(n);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic ck(string nm, logic [15:0] a, logic [31:0] ed, logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, 0, d, r);
        `CHK(nm, ed, d)
        `CHK(nm, er, r)
    endtask

    task automatic tx_ev(logic s, logic e, logic [15:0] o);
        @(posedge aclk);
        tx_pkt_valid <= 1'b1;
        tx_sec <= s;
        tx_enc <= e;
        tx_oct <= o;
        @(posedge aclk);
        tx_pkt_valid <= 1'b0;
    endtask

    task automatic rx_ev(logic u, logic e, logic p, logic [15:0] o, logic b, logic k, logic f);
        @(posedge aclk);
        {rx_pkt_valid, rx_untag, rx_enc, rx_prot, rx_bad, rx_unk, rx_fwd} <= {1'b1, u, e, p, b, k, f};
        rx_oct <= o;
        @(posedge aclk);
        rx_pkt_valid <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_reset();
        for (int i = 0; i < 11; i++)
            ck("cnt_reset", CNT_ADDR[i], 32'h0000_0000, OK);
        ck("ctrl_reset", CTRL, 32'h0000_0000, OK);
        ck("unmapped", 16'h4318, 32'h0000_0000, ERR);
    endtask

    // Mode 11b and 00b must leave both untagged counters still
    task automatic s_enable();
        logic [1:0] m, r;
        for (int i = 0; i < 4; i++)
        begin
            m = i[1:0];
            wr(CTRL, {28'h0, m, m}, r);
            `CHK("ctrl_wr", OK, r)
            `CHK("tx_en", m, tx_en)
            `CHK("rx_en", m, rx_en)
            tx_ev(1'b0, 1'b1, 16'h0010);
            rx_ev(1'b1, 1'b0, 1'b0, 16'h0033, 1'b0, 1'b0, 1'b0);
            ck("tx_ut", CNT_ADDR[0], {31'h0, (m == 2'h1 || m == 2'h2)}, OK);
            ck("rx_ut", CNT_ADDR[5], {31'h0, (m == 2'h1 || m == 2'h2)}, OK);
        end
        wr(CTRL, 32'h0000_0005, r);
        `CHK("ctrl_wr5", OK, r)
        // Without byte lane 0 the enable fields must not move
        wstrb <= 4'h0;
        wr(CTRL, 32'h0000_0000, r);
        `CHK("ctrl_nostrb", OK, r)
        `CHK("tx_en_kept", 2'h1, tx_en)
        `CHK("rx_en_kept", 2'h1, rx_en)
        wstrb <= 4'hF;
    endtask

    // Software side: polled reads build a wide running total
    task automatic s_poll();
        logic [31:0] d;
        logic [1:0]  r;
        logic [63:0] total;
        total = 64'h0000_0000_0000_0000;
        repeat (3)
        begin
            tx_ev(1'b1, 1'b1, 16'hFFFF);
            rd(CNT_ADDR[3], 0, d, r);
            total = total + 64'(d);
        end
        `CHK("eo_total", 64'h0000_0000_0002_FFFD, total)
    endtask

    task automatic s_tx();
        tx_ev(1'b1, 1'b1, 16'h0040);
        tx_ev(1'b1, 1'b1, 16'hFFFF);
        tx_ev(1'b1, 1'b0, 16'h0005);
        ck("tx_ut", CNT_ADDR[0], 32'h0, OK);
        ck("tx_ep", CNT_ADDR[1], 32'h2, OK);
        ck("tx_pp", CNT_ADDR[2], 32'h1, OK);
        ck("tx_eo", CNT_ADDR[3], 32'h0001_003F, OK);
        ck("tx_po", CNT_ADDR[4], 32'h5, OK);
        ck("tx_eo_clr", CNT_ADDR[3], 32'h0, OK);
    endtask

    task automatic s_rx();
        rx_ev(1'b0, 1'b1, 1'b1, 16'h0100, 1'b0, 1'b0, 1'b0);
        rx_ev(1'b0, 1'b0, 1'b1, 16'h0020, 1'b0, 1'b0, 1'b0);
        rx_ev(1'b0, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b0);
        rx_ev(1'b0, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1, 1'b0);
        rx_ev(1'b0, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1, 1'b1);
        rx_ev(1'b0, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1, 1'b1);
        ck("rx_ut", CNT_ADDR[5], 32'h0, OK);
        ck("rx_do", CNT_ADDR[6], 32'h100, OK);
        ck("rx_vo", CNT_ADDR[7], 32'h20, OK);
        ck("rx_bad", CNT_ADDR[8], 32'h1, OK);
        ck("rx_noid", CNT_ADDR[9], 32'h1, OK);
        ck("rx_unk", CNT_ADDR[10], 32'h2, OK);
    endtask

    // Event lands on the clearing edge of the same counter
    task automatic s_coinc();
        logic [31:0] d;
        logic [1:0]  r;
        rx_ev(1'b0, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b0);
        rx_ev(1'b0, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b0);
        rd(CNT_ADDR[8], 1, d, r);
        `CHK("bad_before", 32'h2, d)
        ck("bad_after", CNT_ADDR[8], 32'h1, OK);
    endtask

    task automatic s_wr_cnt();
        logic [1:0] r;
        tx_ev(1'b0, 1'b0, 16'h0001);
        wr(CNT_ADDR[0], 32'hFFFF_FFFF, r);
        `CHK("cnt_wr", ERR, r)
        ck("tx_ut_kept", CNT_ADDR[0], 32'h1, OK);
    endtask

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        s_reset();
        s_enable();
        s_tx();
        s_rx();
        s_coinc();
        s_wr_cnt();
        s_poll();
        print_verdict();
    end
endmodule // secure_link_port_counters_bench
